// file: verilog/bsp_map.svh
// Constants for the bit timed asynchronous serial port
`ifndef BSP_MAP_SVH
`define BSP_MAP_SVH
// ****************************************
// Timing
// ****************************************
`define BSP_CLK_HZ         20000000
`define BSP_BAUD_DEFAULT   2400
`define BSP_BAUD_FAST      9600
// Half bit in cycles, rounded down
`define BSP_HALF_SLOW      ((`BSP_CLK_HZ / `BSP_BAUD_DEFAULT) / 2)
`define BSP_HALF_FAST      ((`BSP_CLK_HZ / `BSP_BAUD_FAST) / 2)
// ****************************************
// Framing
// ****************************************
`define BSP_DATA_BITS      8
`define BSP_IDLE_LEVEL     1'h1
`endif

// file: verilog/bsp_pkg.sv
// Types for the bit timed asynchronous serial port
package bsp_pkg;
   typedef logic [7:0]  bsp_byte_t;   // One character
   typedef logic [12:0] bsp_cnt_t;    // Half bit counter
   // Receiver states, one-hot
   typedef enum logic [3:0] {
      BSP_RX_IDLE  = 4'h1,
      BSP_RX_START = 4'h2,
      BSP_RX_DATA  = 4'h4,
      BSP_RX_STOP  = 4'h8
   } bsp_rx_e;
   // Transmitter states, one-hot
   typedef enum logic [1:0] {
      BSP_TX_IDLE  = 2'h1,
      BSP_TX_SHIFT = 2'h2
   } bsp_tx_e;
endpackage : bsp_pkg

// file: verilog/bsp_half_timer.sv
// Half bit interval timer, one instance for each direction
`include "bsp_map.svh"
module bsp_half_timer
   import bsp_pkg::*;
(
   input  wire logic     i_clk,       // Core clock
   input  wire logic     i_sys_rst,   // Async reset, high
   input  wire logic     i_restart,   // Restart interval
   input  wire logic     i_fast,      // Select fast rate
   output logic          o_tick       // Pulse per half bit
);
   bsp_cnt_t cnt_q;   // Down counter
   bsp_cnt_t cnt_d;   // Next count
   logic     tick_d;  // Next tick
   bsp_cnt_t reload;  // Interval length minus one

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      reload = i_fast ? 13'(`BSP_HALF_FAST - 1) : 13'(`BSP_HALF_SLOW - 1);
      tick_d = 1'b0;
      cnt_d  = cnt_q - 13'h1;
      if (i_restart) begin
         cnt_d = reload;
      end else if (cnt_q == 13'h0) begin
         cnt_d  = reload;
         tick_d = 1'b1;
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cnt_q  <= 13'h0;
         o_tick <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         o_tick <= tick_d;
      end
   end
endmodule : bsp_half_timer

// file: verilog/bsp_serial_port.sv
// Bit timed asynchronous serial port, receiver and transmitter
`include "bsp_map.svh"
module bsp_serial_port
   import bsp_pkg::*;
(
   input  wire logic        i_clk,              // Core clock 20 MHz
   input  wire logic        i_sys_rst,          // Async reset, high
   input  wire logic        i_fast_rate,        // High selects 9600 baud
   input  wire logic        i_receive_line_pin, // Serial input
   output logic             o_rx_valid,         // Received byte pulse
   output bsp_pkg::bsp_byte_t o_rx_data,        // Received byte
   input  wire logic        i_tx_start,         // Send request
   input  wire bsp_pkg::bsp_byte_t i_tx_data,   // Byte to send
   output logic             o_tx_busy,          // Transmitter busy
   output logic             o_transmit_line_pin // Serial output
);
   // ****************************************
   // Input synchroniser
   // ****************************************
   logic [2:0] sync_q;   // Three stage chain
   logic [2:0] sync_d;   // Next chain
   logic       rx_q;     // Filtered line level
   logic       rx_d;     // Next filtered level

   always_comb begin
      sync_d = {sync_q[1:0], i_receive_line_pin};
      rx_d   = rx_q;
      if (sync_q[1] == sync_q[2]) begin
         rx_d = sync_q[1];      // Second and third agree
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         sync_q <= 3'h7;
         rx_q   <= 1'b1;
      end else begin
         sync_q <= sync_d;
         rx_q   <= rx_d;
      end
   end

   // ****************************************
   // Receiver
   // ****************************************
   bsp_rx_e    rst_q, rst_d;     // Receive state
   logic [4:0] rhalf_q, rhalf_d; // Half bits counted
   bsp_byte_t  rsh_q, rsh_d;     // Receive shifter
   logic       rrestart;         // Restart rx timer
   logic       rtick;            // Rx half bit tick
   logic       rvalid_d;         // Next valid pulse
   bsp_byte_t  rdata_d;          // Next data output

   bsp_half_timer u_rx_timer (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_restart (rrestart),
      .i_fast    (i_fast_rate),
      .o_tick    (rtick)
   );

   always_comb begin
      rst_d    = rst_q;
      rhalf_d  = rhalf_q;
      rsh_d    = rsh_q;
      rrestart = 1'b0;
      rvalid_d = 1'b0;
      rdata_d  = o_rx_data;
      case (rst_q)
         BSP_RX_IDLE: begin
            rrestart = 1'b1;
            rhalf_d  = 5'h0;
            if (!rx_q) begin
               rst_d = BSP_RX_START;   // Falling edge seen
            end
         end
         BSP_RX_START: begin
            if (rtick) begin
               rst_d   = BSP_RX_DATA;  // Middle of start bit
               rhalf_d = 5'h0;
            end
         end
         BSP_RX_DATA: begin
            if (rtick) begin
               rhalf_d = rhalf_q + 5'h1;
               if (rhalf_q[0]) begin
                  rsh_d = {rx_q, rsh_q[7:1]};  // Single centre sample
                  if (rhalf_q == 5'(2 * `BSP_DATA_BITS - 1)) begin
                     rst_d = BSP_RX_STOP;
                  end
               end
            end
         end
         BSP_RX_STOP: begin
            rvalid_d = 1'b1;
            rdata_d  = rsh_q;
            rst_d    = BSP_RX_IDLE;         // Stop level ignored
         end
         default: begin
            rst_d = BSP_RX_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         rst_q      <= BSP_RX_IDLE;
         rhalf_q    <= 5'h0;
         rsh_q      <= 8'h00;
         o_rx_valid <= 1'b0;
         o_rx_data  <= 8'h00;
      end else begin
         rst_q      <= rst_d;
         rhalf_q    <= rhalf_d;
         rsh_q      <= rsh_d;
         o_rx_valid <= rvalid_d;
         o_rx_data  <= rdata_d;
      end
   end

   // ****************************************
   // Transmitter
   // ****************************************
   bsp_tx_e    tst_q, tst_d;     // Transmit state
   logic [4:0] thalf_q, thalf_d; // Half bits sent
   logic [9:0] tsh_q, tsh_d;     // Frame shifter
   logic       trestart;         // Restart tx timer
   logic       ttick;            // Tx half bit tick
   logic       line_d;           // Next line level
   logic       busy_d;           // Next busy

   bsp_half_timer u_tx_timer (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_restart (trestart),
      .i_fast    (i_fast_rate),
      .o_tick    (ttick)
   );

   always_comb begin
      tst_d    = tst_q;
      thalf_d  = thalf_q;
      tsh_d    = tsh_q;
      trestart = 1'b0;
      line_d   = o_transmit_line_pin;
      busy_d   = o_tx_busy;
      case (tst_q)
         BSP_TX_IDLE: begin
            trestart = 1'b1;
            line_d   = `BSP_IDLE_LEVEL;
            busy_d   = 1'b0;
            if (i_tx_start) begin
               tsh_d   = {1'b1, i_tx_data, 1'b0};  // Stop, data, start
               thalf_d = 5'h0;
               line_d  = 1'b0;
               busy_d  = 1'b1;
               tst_d   = BSP_TX_SHIFT;
            end
         end
         BSP_TX_SHIFT: begin
            if (ttick) begin
               thalf_d = thalf_q + 5'h1;
               if (thalf_q[0]) begin
                  tsh_d  = {1'b1, tsh_q[9:1]};    // Two half bits per bit
                  line_d = tsh_q[1];
                  if (thalf_q == 5'(2 * (`BSP_DATA_BITS + 2) - 1)) begin
                     line_d = `BSP_IDLE_LEVEL;
                     busy_d = 1'b0;
                     tst_d  = BSP_TX_IDLE;        // Back to idle high
                  end
               end
            end
         end
         default: begin
            tst_d = BSP_TX_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         tst_q               <= BSP_TX_IDLE;
         thalf_q             <= 5'h0;
         tsh_q               <= 10'h3FF;
         o_tx_busy           <= 1'b0;
         o_transmit_line_pin <= `BSP_IDLE_LEVEL;
      end else begin
         tst_q               <= tst_d;
         thalf_q             <= thalf_d;
         tsh_q               <= tsh_d;
         o_tx_busy           <= busy_d;
         o_transmit_line_pin <= line_d;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   sequence s_tx_go;
      tst_q == BSP_TX_IDLE && i_tx_start;
   endsequence
   property p_tx_start_low;
      @(posedge i_clk) disable iff (i_sys_rst)
         s_tx_go |=> !o_transmit_line_pin && o_tx_busy;
   endproperty
   a_tx_start_low: assert property (p_tx_start_low)
      else $error("start bit not driven low");
   property p_idle_high;
      @(posedge i_clk) disable iff (i_sys_rst)
         !o_tx_busy |-> o_transmit_line_pin;
   endproperty
   a_idle_high: assert property (p_idle_high)
      else $error("idle line not high");
   property p_rx_wait;
      @(posedge i_clk) disable iff (i_sys_rst)
         (rst_q == BSP_RX_IDLE && rx_q) |=> rst_q == BSP_RX_IDLE;
   endproperty
   a_rx_wait: assert property (p_rx_wait)
      else $error("receiver left idle without low");
   property p_rx_valid_pulse;
      @(posedge i_clk) disable iff (i_sys_rst)
         o_rx_valid |=> !o_rx_valid;
   endproperty
   a_rx_valid_pulse: assert property (p_rx_valid_pulse)
      else $error("valid longer than one cycle");
   property p_rx_stop_ignored;
      @(posedge i_clk) disable iff (i_sys_rst)
         rst_q == BSP_RX_STOP |=> o_rx_valid && rst_q == BSP_RX_IDLE;
   endproperty
   a_rx_stop_ignored: assert property (p_rx_stop_ignored)
      else $error("byte not delivered at stop");
   property p_rx_data_value;
      @(posedge i_clk) disable iff (i_sys_rst)
         o_rx_valid |-> o_rx_data == $past(rsh_q);
   endproperty
   a_rx_data_value: assert property (p_rx_data_value)
      else $error("wrong received byte");
   property p_busy_stable;
      @(posedge i_clk) disable iff (i_sys_rst)
         (o_tx_busy && !ttick) |=> o_tx_busy;
   endproperty
   a_busy_stable: assert property (p_busy_stable)
      else $error("busy dropped off tick");
   property p_line_changes_on_tick;
      @(posedge i_clk) disable iff (i_sys_rst)
         ($past(o_tx_busy) && o_tx_busy && $changed(o_transmit_line_pin)) |-> $past(ttick);
   endproperty
   a_line_changes_on_tick: assert property (p_line_changes_on_tick)
      else $error("line changed without timer tick");
endmodule : bsp_serial_port

// file: testbench/bsp_host_model.sv
// Host side serial port model facing the bit timed serial port
`include "bsp_map.svh"
module bsp_host_model #(
   parameter int HALF = `BSP_HALF_SLOW   // Half bit cycles, default rate
) (
   input  wire logic i_clk,   // Core clock
   input  wire logic i_line,  // Line from the device
   output logic      o_line   // Line to the device
);
   timeunit 1ns;
   timeprecision 1ns;
   // Line rests high between frames
   initial o_line = `BSP_IDLE_LEVEL;
   // ****************************************
   // Send one frame, stop level chosen
   // ****************************************
   task automatic send(input logic [7:0] b, input logic stp);
      logic [9:0] f;
      f = {stp, b, 1'h0};   // Start, LSB first, stop
      for (int i = 0; i < 10; i++) begin
         @(negedge i_clk);
         o_line <= f[i];
         repeat (2 * HALF - 1) @(negedge i_clk);
      end
      @(negedge i_clk);
      o_line <= 1'h1;
   endtask : send
   // ****************************************
   // Capture one frame at bit centres
   // ****************************************
   task automatic rcv(output logic [7:0] b, output logic stp, output logic ok);
      int n;
      n = 0;
      b = 8'h00;
      stp = 1'h0;
      // Bounded hunt for the start edge
      while (i_line !== 1'h0 && n < 8 * HALF) begin
         @(negedge i_clk);
         n++;
      end
      ok = (i_line === 1'h0);
      repeat (HALF) @(negedge i_clk);
      for (int i = 0; i < 8; i++) begin   // LSB first
         repeat (2 * HALF) @(negedge i_clk);
         b[i] = i_line;
      end
      repeat (2 * HALF) @(negedge i_clk);
      stp = i_line;
   endtask : rcv
endmodule : bsp_host_model

// file: testbench/tb.sv
// Self-checking testbench for the bit timed serial port
`include "bsp_map.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import bsp_pkg::*;
   localparam int HALF = `BSP_HALF_FAST;  // Fast rate half bit
   localparam int HALF_SLOW = `BSP_HALF_SLOW;  // Default rate half bit
   logic      clk;        // Core clock
   logic      rst;        // Reset, high
   logic      fast;       // Rate select
   logic      rxl;        // Line into device
   logic      rxv;        // Byte pulse
   logic      txs;        // Send request
   logic      busy;       // Transmitter busy
   logic      txl;        // Line out of device
   bsp_byte_t rxd;        // Received byte
   bsp_byte_t txd;        // Byte to send
   int        fails;      // Mismatch count
   int        tests_run;  // Comparison count
   bsp_serial_port dut (
      .i_clk(clk), .i_sys_rst(rst), .i_fast_rate(fast), .i_receive_line_pin(rxl),
      .o_rx_valid(rxv), .o_rx_data(rxd), .i_tx_start(txs), .i_tx_data(txd),
      .o_tx_busy(busy), .o_transmit_line_pin(txl)
   );
   bsp_host_model #(.HALF(HALF)) host (.i_clk(clk), .i_line(txl), .o_line(rxl));
   // Half period toggle
   always #25 clk = ~clk;
   // Expected frame bits, start first
   function automatic logic [9:0] frame(input bsp_byte_t b);
      return {1'h1, b, 1'h0};
   endfunction : frame
   task automatic chk1(input logic g, input logic e);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %0t bit %b exp %b", $time, g, e);
      end
   endtask : chk1
   task automatic chk8(input bsp_byte_t g, input bsp_byte_t e);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %0t byte %h exp %h", $time, g, e);
      end
   endtask : chk8
   task automatic chkr(input int g, input int lo, input int hi);
      tests_run++;
      if (g < lo || g > hi) begin
         fails++;
         $display("MISMATCH %0t count %0d exp %0d to %0d", $time, g, lo, hi);
      end
   endtask : chkr
   task automatic summarize;
      $display("Checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : summarize
   // Bounded wait: sel 1 for busy level, 0 for valid pulse
   task automatic wait_for(input bit sel, input logic v, input int lim);
      int n;
      n = 0;
      while ((sel ? busy : rxv) !== v && n < lim) begin
         @(negedge clk);
         n++;
      end
      if ((sel ? busy : rxv) !== v) begin
         fails++;
         $display("MISMATCH %0t wait timed out", $time);
         summarize();
      end
   endtask : wait_for
   // ****************************************
   // Receive one frame from the host
   // ****************************************
   task automatic rx_case(input bsp_byte_t b, input logic stp);
      fork
         host.send(b, stp);
         begin
            wait_for(1'b0, 1'h1, 22 * HALF);
            chk8(rxd, b);
            @(negedge clk);
            chk1(rxv, 1'h0);
         end
      join
   endtask : rx_case
   // ****************************************
   // Send one frame, with a refused request
   // ****************************************
   task automatic tx_case(input bsp_byte_t a, input bsp_byte_t other);
      logic [7:0]  g;
      logic        s;
      logic        ok;
      logic [9:0]  f;
      f = frame(a);
      fork
         host.rcv(g, s, ok);
         begin
            @(negedge clk);
            txd = a;
            txs = 1'h1;
            @(negedge clk);
            txs = 1'h0;
            txd = other;
            @(negedge clk);
            chk1(busy, 1'h1);
            chk1(txl, f[0]);
            // Request while busy must be ignored
            repeat (3 * HALF) @(negedge clk);
            txs = 1'h1;
            @(negedge clk);
            txs = 1'h0;
         end
      join
      chk1(ok, 1'h1);
      chk8(g, f[8:1]);
      chk1(s, f[9]);
      wait_for(1'b1, 1'h0, 4 * HALF);
      chk1(txl, 1'h1);
   endtask : tx_case
   // ****************************************
   // Default rate start bit, mid-run resets
   // ****************************************
   task automatic slow_case;
      int n;
      n = 0;
      // Reset also ends any frame the low stop bit began
      @(negedge clk);
      rst = 1'h1;
      fast = 1'h0;                 // Rate changed while held idle
      repeat (2) @(negedge clk);
      chk1(txl, 1'h1);
      chk1(busy, 1'h0);
      chk1(rxv, 1'h0);
      chk8(rxd, 8'h00);
      rst = 1'h0;
      @(negedge clk);
      txd = bsp_byte_t'($urandom) | 8'h01;  // High first bit ends start bit visibly
      txs = 1'h1;
      @(negedge clk);
      txs = 1'h0;
      // Bounded count of low cycles of the start bit
      while (txl === 1'h0 && n < 3 * HALF_SLOW) begin
         n++;
         @(negedge clk);
      end
      chkr(n, 2 * HALF_SLOW, 2 * HALF_SLOW + 1);
      chk1(busy, 1'h1);
      // Reset in mid frame returns the line to idle
      rst = 1'h1;
      @(negedge clk);
      chk1(txl, 1'h1);
      chk1(busy, 1'h0);
      rst = 1'h0;
      repeat (2) @(negedge clk);
      chk1(txl, 1'h1);
      chk1(busy, 1'h0);
   endtask : slow_case
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      clk = 1'h0;
      rst = 1'h1;
      fast = 1'h1;
      txs = 1'h0;
      txd = 8'h00;
      fails = 0;
      tests_run = 0;
      void'($urandom(32'h1087));
      repeat (20) @(negedge clk);
      chk1(txl, 1'h1);
      chk1(busy, 1'h0);
      chk1(rxv, 1'h0);
      chk8(rxd, 8'h00);
      rst = 1'h0;
      fork
         begin
            rx_case(bsp_byte_t'($urandom), 1'h1);
            rx_case(8'h80, 1'h0);  // Low stop bit accepted
         end
         begin
            tx_case(bsp_byte_t'($urandom), 8'h01);
            tx_case(8'hFE, 8'h00); // Back to back once idle
         end
      join
      slow_case();
      summarize();
   end
endmodule : tb
